// ===== rtl/nfcs_pkg.sv
package nfcs_pkg;
	// Clock period and timing figures in their own units
	localparam int CLK_PERIOD_NS = 5; // 200 MHz
	localparam int T_SETUP_NS = 10; // Address to strobe setup
	localparam int T_WPULSE_NS = 45; // Write strobe low time
	localparam int T_ACCESS_NS = 90; // Read strobe to data valid
	localparam int T_HOLD_NS = 20; // Hold after strobe rise
	localparam int T_BUSY_NS = 90; // Strobe rise to busy output valid
	localparam int T_RSTLOW_NS = 500; // Hardware reset pulse
	localparam int T_RSTREC_NS = 50; // Recovery after reset release
	localparam int T_WINDOW_NS = 50000; // Sector-load window

	// Least times round up to whole cycles
	localparam int CYC_SETUP = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_WPULSE = (T_WPULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_ACCESS = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_HOLD = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_BUSY = (T_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_RSTLOW = (T_RSTLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_RSTREC = (T_RSTREC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Longest time rounds down
	localparam int CYC_WINDOW = T_WINDOW_NS / CLK_PERIOD_NS;

	// Flash bus widths (word mode)
	localparam int ADDR_W = 22;
	localparam int DATA_W = 16;

	// Register byte offsets of the controller's own map
	localparam logic [4:0] REG_CMD = 5'h00;
	localparam logic [4:0] REG_ADDR = 5'h04;
	localparam logic [4:0] REG_WDATA = 5'h08;
	localparam logic [4:0] REG_RDATA = 5'h0C;
	localparam logic [4:0] REG_STATUS = 5'h10;

	// Status register bit positions
	localparam int ST_ACTIVE = 0;
	localparam int ST_READY_PIN = 1;
	localparam int ST_ALG = 2;
	localparam int ST_WINDOW = 3;
	localparam int ST_IDMODE = 4;
	localparam int ST_SUSP = 5;
	localparam int ST_ERR = 6;

	// Command codes written to the command register
	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_RESET = 4'h1,
		OP_ID = 4'h2,
		OP_PROG = 4'h3,
		OP_CHIP = 4'h4,
		OP_SECT = 4'h5,
		OP_SUSPEND = 4'h6,
		OP_RESUME = 4'h7,
		OP_READ = 4'h8,
		OP_HWRST = 4'h9,
		OP_ADDSECT = 4'hA
	} nfcs_op_e;

	// Flash command bytes and unlock addresses
	localparam logic [ADDR_W-1:0] UNLOCK_A1 = 22'h000555;
	localparam logic [ADDR_W-1:0] UNLOCK_A2 = 22'h0002AA;
	localparam logic [7:0] CD_UNLOCK1 = 8'hAA;
	localparam logic [7:0] CD_UNLOCK2 = 8'h55;
	localparam logic [7:0] CD_RESET = 8'hF0;
	localparam logic [7:0] CD_ID = 8'h90;
	localparam logic [7:0] CD_PROG = 8'hA0;
	localparam logic [7:0] CD_ERASE = 8'h80;
	localparam logic [7:0] CD_CHIP = 8'h10;
	localparam logic [7:0] CD_SECT = 8'h30;
	localparam logic [7:0] CD_SUSPEND = 8'hB0;
	localparam logic [7:0] CD_RESUME = 8'h30;
endpackage

// ===== rtl/nfcs_bus_cycle.sv
`timescale 1ns/10ps
module nfcs_bus_cycle
(
	input wire logic clk, // System clock
	input wire logic srst, // Sync reset, also aborts a cycle
	input wire logic start, // Begin one bus cycle
	input wire logic wr, // 1 write, 0 read
	input wire logic [nfcs_pkg::ADDR_W-1:0] addr, // Cycle address
	input wire logic [nfcs_pkg::DATA_W-1:0] wdata, // Write data
	input wire logic [nfcs_pkg::DATA_W-1:0] dq_in, // Flash data pins in
	output logic [nfcs_pkg::ADDR_W-1:0] addr_o, // Flash address pins
	output logic [nfcs_pkg::DATA_W-1:0] dq_out, // Flash data pins out
	output logic dq_oe_n, // Low while driving data
	output logic ce_n, // Chip select
	output logic we_n, // Write strobe
	output logic oe_n, // Output enable
	output logic [nfcs_pkg::DATA_W-1:0] rdata, // Captured read data
	output logic done // One-cycle end pulse
);
	// Cycle phases
	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_SETUP = 2'b01,
		PH_STROBE = 2'b10,
		PH_HOLD = 2'b11
	} nfcs_ph_e;

	nfcs_ph_e ph; // Current phase
	logic [4:0] cnt; // Phase cycle counter
	logic is_wr; // Latched direction
	wire cnt_end = (cnt == 5'h00); // Phase time elapsed
	wire [4:0] strobe_len = is_wr ? 5'(nfcs_pkg::CYC_WPULSE - 1) : 5'(nfcs_pkg::CYC_ACCESS - 1);

	// Phase sequencer, pins registered so they change cleanly
	always_ff @(posedge clk)
	begin
		done <= 1'b0;
		if (srst)
		begin
			ph <= PH_IDLE;
			cnt <= 5'h00;
			is_wr <= 1'b0;
			addr_o <= '0;
			dq_out <= '0;
			dq_oe_n <= 1'b1;
			ce_n <= 1'b1;
			we_n <= 1'b1;
			oe_n <= 1'b1;
			rdata <= '0;
		end
		else
		begin
			unique case (ph)
				PH_IDLE:
				begin
					// Address and data settle before the strobe
					if (start)
					begin
						ph <= PH_SETUP;
						cnt <= 5'(nfcs_pkg::CYC_SETUP - 1);
						is_wr <= wr;
						addr_o <= addr;
						dq_out <= wdata;
						dq_oe_n <= !wr;
						ce_n <= 1'b0;
					end
				end
				PH_SETUP:
				begin
					// Assert the strobe once setup has elapsed
					if (cnt_end)
					begin
						ph <= PH_STROBE;
						cnt <= strobe_len;
						we_n <= !is_wr;
						oe_n <= is_wr;
					end
					else
						cnt <= cnt - 5'h01;
				end
				PH_STROBE:
				begin
					// Rising edge latches command data in the flash
					if (cnt_end)
					begin
						ph <= PH_HOLD;
						cnt <= 5'(nfcs_pkg::CYC_HOLD - 1);
						we_n <= 1'b1;
						oe_n <= 1'b1;
						ce_n <= 1'b1;
						if (!is_wr)
							rdata <= dq_in;
					end
					else
						cnt <= cnt - 5'h01;
				end
				PH_HOLD:
				begin
					// Keep address and data stable, then release the bus
					if (cnt_end)
					begin
						ph <= PH_IDLE;
						dq_oe_n <= 1'b1;
						done <= 1'b1;
					end
					else
						cnt <= cnt - 5'h01;
				end
			endcase
		end
	end
endmodule // nfcs_bus_cycle

// ===== rtl/nfcs_ctrl.sv
`timescale 1ns/10ps
// Overview of operation
// - Only reset command or hardware reset leaves identifier mode
// - Program is four writes, then self-timed
// - Commands ignored while programming; reissue after reset
// - Erase is six writes ending 10H or 30H
// - Hardware reset aborts erase; reissue afterwards
// - Next sector load within 50us of previous
module nfcs_ctrl
#(
	parameter int WIN_CYC = nfcs_pkg::CYC_WINDOW // Sector-load window in cycles
)
(
	input wire logic clk, // System clock
	input wire logic srst, // Sync reset, active high
	input wire logic [4:0] reg_addr, // Register byte address
	input wire logic [31:0] reg_wdata, // Register write data
	input wire logic reg_wr, // Register write strobe
	input wire logic reg_rd, // Register read strobe
	output logic [31:0] reg_rdata, // Read data, cycle after strobe
	output logic [nfcs_pkg::ADDR_W-1:0] flash_addr, // Flash address
	output logic [nfcs_pkg::DATA_W-1:0] flash_dq_out, // Flash data out
	input wire logic [nfcs_pkg::DATA_W-1:0] flash_dq_in, // Flash data in
	output logic flash_dq_oe_n, // Low while driving data
	output logic flash_ce_n, // Chip select, active low
	output logic flash_we_n, // Write strobe, active low
	output logic flash_oe_n, // Output enable, active low
	output logic flash_reset_n, // Hardware reset, active low
	input wire logic ready_busy_out // Flash ready (1) or busy (0)
);
	// Sequencer states
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_ISSUE = 3'b001,
		S_WAIT = 3'b010,
		S_BUSY = 3'b011,
		S_HWRST = 3'b100,
		S_HREC = 3'b101
	} nfcs_st_e;

	nfcs_st_e state; // Current state
	nfcs_pkg::nfcs_op_e cur_op; // Operation being issued
	nfcs_pkg::nfcs_op_e alg_op; // Last algorithm started
	logic [2:0] idx; // Write index within a sequence
	logic [nfcs_pkg::ADDR_W-1:0] addr_reg; // Software address
	logic [nfcs_pkg::DATA_W-1:0] wdata_reg; // Software data
	logic [nfcs_pkg::ADDR_W-1:0] lat_addr; // Address held for the sequence
	logic [nfcs_pkg::DATA_W-1:0] lat_data; // Data held for the sequence
	logic [nfcs_pkg::DATA_W-1:0] rdata_reg; // Last flash read
	logic id_mode; // Flash in identifier mode
	logic susp; // Erase suspended
	logic sect_alg; // Sector erase running or loading
	logic suspending; // Waiting for suspend to settle
	logic redo; // Reissue after hardware reset
	logic err; // Refused command, sticky
	logic rdy_q; // Sampled ready pin
	logic [7:0] cnt; // Busy delay and reset counter
	logic [15:0] win_tmr; // Time since last sector load

	// Address and data of step i of a sequence
	function automatic logic [nfcs_pkg::ADDR_W+7:0] step(input nfcs_pkg::nfcs_op_e op, input logic [2:0] i,
		input logic [nfcs_pkg::ADDR_W-1:0] a, input logic [7:0] d);
		logic [nfcs_pkg::ADDR_W+7:0] r;
		r = (i == 3'd1 || i == 3'd4) ? {nfcs_pkg::UNLOCK_A2, nfcs_pkg::CD_UNLOCK2}
			: {nfcs_pkg::UNLOCK_A1, nfcs_pkg::CD_UNLOCK1};
		unique case (op)
			nfcs_pkg::OP_RESET: r = {a, nfcs_pkg::CD_RESET};
			nfcs_pkg::OP_SUSPEND: r = {a, nfcs_pkg::CD_SUSPEND};
			nfcs_pkg::OP_RESUME: r = {a, nfcs_pkg::CD_RESUME};
			nfcs_pkg::OP_ADDSECT: r = {a, nfcs_pkg::CD_SECT};
			nfcs_pkg::OP_READ: r = {a, d};
			nfcs_pkg::OP_ID: if (i == 3'd2) r = {nfcs_pkg::UNLOCK_A1, nfcs_pkg::CD_ID};
			nfcs_pkg::OP_PROG:
			begin
				if (i == 3'd2) r = {nfcs_pkg::UNLOCK_A1, nfcs_pkg::CD_PROG};
				if (i == 3'd3) r = {a, d};
			end
			nfcs_pkg::OP_CHIP, nfcs_pkg::OP_SECT:
			begin
				if (i == 3'd2) r = {nfcs_pkg::UNLOCK_A1, nfcs_pkg::CD_ERASE};
				if (i == 3'd5) r = (op == nfcs_pkg::OP_CHIP) ? {nfcs_pkg::UNLOCK_A1, nfcs_pkg::CD_CHIP}
					: {a, nfcs_pkg::CD_SECT};
			end
			default: r = {a, d};
		endcase
		return r;
	endfunction

	// Number of bus cycles of each operation
	function automatic logic [2:0] seq_len(input nfcs_pkg::nfcs_op_e op);
		unique case (op)
			nfcs_pkg::OP_ID: return 3'd3;
			nfcs_pkg::OP_PROG: return 3'd4;
			nfcs_pkg::OP_CHIP, nfcs_pkg::OP_SECT: return 3'd6;
			default: return 3'd1;
		endcase
	endfunction

	// Decode of register accesses and command acceptance
	wire [nfcs_pkg::ADDR_W+7:0] cur_step = step(cur_op, idx, lat_addr, lat_data[7:0]);
	wire cyc_start = (state == S_ISSUE);
	wire cyc_wr = (cur_op != nfcs_pkg::OP_READ);
	wire [nfcs_pkg::DATA_W-1:0] cyc_wdata = (cur_op == nfcs_pkg::OP_PROG && idx == 3'd3) ? lat_data
		: {8'h00, cur_step[7:0]};
	wire cyc_rst = srst || (state == S_HWRST);
	wire cyc_done;
	wire [nfcs_pkg::DATA_W-1:0] cyc_rdata;
	wire win_open = sect_alg && !susp && (win_tmr < 16'(WIN_CYC - nfcs_pkg::CYC_SETUP));
	wire cmd_wr = reg_wr && (reg_addr == nfcs_pkg::REG_CMD);
	wire [3:0] cmd_code = reg_wdata[3:0];
	wire idle = (state == S_IDLE);
	wire last_step = (idx == seq_len(cur_op) - 3'd1);
	wire alg_kind = (cur_op == nfcs_pkg::OP_PROG) || (cur_op == nfcs_pkg::OP_CHIP)
		|| (cur_op == nfcs_pkg::OP_SECT) || (cur_op == nfcs_pkg::OP_RESUME) || (cur_op == nfcs_pkg::OP_ADDSECT);
	logic cmd_ok; // Command legal in the present state

	// Legality: busy flash takes only hardware reset, suspend or a further sector load
	always_comb
	begin
		unique case (cmd_code)
			nfcs_pkg::OP_HWRST: cmd_ok = 1'b1;
			nfcs_pkg::OP_RESET, nfcs_pkg::OP_READ: cmd_ok = idle;
			nfcs_pkg::OP_ID, nfcs_pkg::OP_PROG: cmd_ok = idle && !id_mode;
			nfcs_pkg::OP_CHIP, nfcs_pkg::OP_SECT: cmd_ok = idle && !id_mode && !susp;
			nfcs_pkg::OP_SUSPEND: cmd_ok = (state == S_BUSY) && sect_alg && !susp && !suspending;
			nfcs_pkg::OP_RESUME: cmd_ok = idle && susp && !id_mode;
			nfcs_pkg::OP_ADDSECT: cmd_ok = (state == S_BUSY) && win_open;
			default: cmd_ok = 1'b0;
		endcase
	end
	wire cmd_acc = cmd_wr && cmd_ok;

	// One bus cycle at a time to the flash pins
	nfcs_bus_cycle u_cyc
	(
		.clk(clk),
		.srst(cyc_rst),
		.start(cyc_start),
		.wr(cyc_wr),
		.addr(cur_step[nfcs_pkg::ADDR_W+7:8]),
		.wdata(cyc_wdata),
		.dq_in(flash_dq_in),
		.addr_o(flash_addr),
		.dq_out(flash_dq_out),
		.dq_oe_n(flash_dq_oe_n),
		.ce_n(flash_ce_n),
		.we_n(flash_we_n),
		.oe_n(flash_oe_n),
		.rdata(cyc_rdata),
		.done(cyc_done)
	);

	// Software-written address and data registers
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			addr_reg <= '0;
			wdata_reg <= '0;
		end
		else if (reg_wr && reg_addr == nfcs_pkg::REG_ADDR)
			addr_reg <= reg_wdata[nfcs_pkg::ADDR_W-1:0];
		else if (reg_wr && reg_addr == nfcs_pkg::REG_WDATA)
			wdata_reg <= reg_wdata[nfcs_pkg::DATA_W-1:0];
	end

	// Register read mux, data one cycle after the strobe
	always_ff @(posedge clk)
	begin
		if (srst)
			reg_rdata <= 32'h00000000;
		else if (reg_rd)
		begin
			unique case (reg_addr)
				nfcs_pkg::REG_ADDR: reg_rdata <= 32'(addr_reg);
				nfcs_pkg::REG_WDATA: reg_rdata <= 32'(wdata_reg);
				nfcs_pkg::REG_RDATA: reg_rdata <= 32'(rdata_reg);
				nfcs_pkg::REG_STATUS: reg_rdata <= 32'({err, susp, id_mode, win_open, state == S_BUSY, rdy_q, !idle});
				default: reg_rdata <= 32'h00000000;
			endcase
		end
	end

	// Refused-command flag: set wins over the status write that clears it
	always_ff @(posedge clk)
	begin
		if (srst)
			err <= 1'b0;
		else if (cmd_wr && !cmd_ok)
			err <= 1'b1;
		else if (reg_wr && reg_addr == nfcs_pkg::REG_STATUS && reg_wdata[nfcs_pkg::ST_ERR])
			err <= 1'b0;
	end

	// Sector-load window timer, restarted by each sector load
	always_ff @(posedge clk)
	begin
		rdy_q <= srst ? 1'b1 : ready_busy_out;
		if (srst)
			win_tmr <= 16'hFFFF;
		else if (cyc_done && (cur_op == nfcs_pkg::OP_SECT || cur_op == nfcs_pkg::OP_ADDSECT) && last_step)
			win_tmr <= 16'h0000;
		else if (win_tmr != 16'hFFFF)
			win_tmr <= win_tmr + 16'h0001;
	end

	// Main sequencer
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			state <= S_IDLE;
			cur_op <= nfcs_pkg::OP_NONE;
			alg_op <= nfcs_pkg::OP_NONE;
			idx <= 3'd0;
			lat_addr <= '0;
			lat_data <= '0;
			rdata_reg <= '0;
			id_mode <= 1'b0;
			susp <= 1'b0;
			sect_alg <= 1'b0;
			suspending <= 1'b0;
			redo <= 1'b0;
			cnt <= 8'h00;
			flash_reset_n <= 1'b1;
		end
		else if (cmd_acc && cmd_code == nfcs_pkg::OP_HWRST)
		begin
			// Reissue an aborted program or erase afterwards
			redo <= (state == S_BUSY) && !suspending && !susp && alg_op != nfcs_pkg::OP_NONE;
			state <= S_HWRST;
			cnt <= 8'(nfcs_pkg::CYC_RSTLOW - 1);
			flash_reset_n <= 1'b0;
			id_mode <= 1'b0;
			susp <= 1'b0;
			sect_alg <= 1'b0;
			suspending <= 1'b0;
		end
		else
		begin
			unique case (state)
				S_IDLE, S_BUSY:
				begin
					if (cmd_acc)
					begin
						// Take the command and freeze its operands
						cur_op <= nfcs_pkg::nfcs_op_e'(cmd_code);
						idx <= 3'd0;
						lat_addr <= addr_reg;
						lat_data <= wdata_reg;
						state <= S_ISSUE;
					end
					else if (state == S_BUSY)
					begin
						// Wait out busy delay, then for the ready pin and a closed load window
						if (cnt != 8'h00)
							cnt <= cnt - 8'h01;
						else if (rdy_q && !win_open)
						begin
							state <= S_IDLE;
							susp <= susp || suspending;
							sect_alg <= suspending;
							suspending <= 1'b0;
							alg_op <= nfcs_pkg::OP_NONE;
						end
					end
				end
				S_ISSUE:
					state <= S_WAIT;
				S_WAIT:
				begin
					if (cyc_done && !last_step)
					begin
						idx <= idx + 3'd1;
						state <= S_ISSUE;
					end
					else if (cyc_done)
					begin
						// Last write: enter mode or start watching busy
						state <= S_IDLE;
						if (cur_op == nfcs_pkg::OP_READ)
							rdata_reg <= cyc_rdata;
						if (cur_op == nfcs_pkg::OP_ID)
							id_mode <= 1'b1;
						if (cur_op == nfcs_pkg::OP_RESET)
							id_mode <= 1'b0;
						if (cur_op == nfcs_pkg::OP_RESUME)
							susp <= 1'b0;
						if (alg_kind || cur_op == nfcs_pkg::OP_SUSPEND)
						begin
							state <= S_BUSY;
							cnt <= 8'(nfcs_pkg::CYC_BUSY);
						end
						if (cur_op == nfcs_pkg::OP_SUSPEND)
							suspending <= 1'b1;
						if (cur_op == nfcs_pkg::OP_SECT || cur_op == nfcs_pkg::OP_RESUME)
							sect_alg <= 1'b1;
						if (cur_op == nfcs_pkg::OP_PROG || cur_op == nfcs_pkg::OP_CHIP || cur_op == nfcs_pkg::OP_SECT)
							alg_op <= cur_op;
						if (cur_op == nfcs_pkg::OP_PROG && susp)
							alg_op <= nfcs_pkg::OP_NONE;
					end
				end
				S_HWRST:
				begin
					// Hold reset low, then give the flash time to recover
					if (cnt != 8'h00)
						cnt <= cnt - 8'h01;
					else
					begin
						flash_reset_n <= 1'b1;
						cnt <= 8'(nfcs_pkg::CYC_RSTREC - 1);
						state <= S_HREC;
					end
				end
				S_HREC:
				begin
					if (cnt != 8'h00)
						cnt <= cnt - 8'h01;
					else if (redo)
					begin
						cur_op <= alg_op;
						idx <= 3'd0;
						redo <= 1'b0;
						state <= S_ISSUE;
					end
					else
					begin
						alg_op <= nfcs_pkg::OP_NONE;
						state <= S_IDLE;
					end
				end
				default:
					state <= S_IDLE;
			endcase
		end
	end

	localparam int WE_LOW_MIN = 8; // Shortest checked strobe run

	// Program: the fourth write hands over to the busy watch
	sequence s_prog_last;
		cyc_done && cur_op == nfcs_pkg::OP_PROG && idx == 3'd3;
	endsequence
	property p_prog_four;
		@(posedge clk) disable iff (srst) s_prog_last |=> state == S_BUSY && flash_ce_n;
	endproperty
	a_prog_four: assert property (p_prog_four) else $error("program did not enter busy after fourth write");

	// Write strobe stays low long enough once it falls
	property p_we_width;
		@(posedge clk) disable iff (srst) $fell(flash_we_n) |-> !flash_we_n [*8];
	endproperty
	a_we_width: assert property (p_we_width) else $error("write strobe too short");

	// Erase final write carries the chip or sector command byte
	sequence s_erase_last;
		cyc_start && (cur_op == nfcs_pkg::OP_CHIP || cur_op == nfcs_pkg::OP_SECT) && idx == 3'd5;
	endsequence
	property p_erase_six;
		@(posedge clk) disable iff (srst) s_erase_last |->
			cyc_wdata[7:0] == ((cur_op == nfcs_pkg::OP_CHIP) ? nfcs_pkg::CD_CHIP : nfcs_pkg::CD_SECT);
	endproperty
	a_erase_six: assert property (p_erase_six) else $error("erase sequence ended with wrong command");

	// Identifier mode is left only by reset command or hardware reset
	property p_id_hold;
		@(posedge clk) disable iff (srst) id_mode && !(cyc_done && cur_op == nfcs_pkg::OP_RESET)
			&& !(cmd_acc && cmd_code == nfcs_pkg::OP_HWRST) |=> id_mode;
	endproperty
	a_id_hold: assert property (p_id_hold) else $error("identifier mode left without reset");

	// Sector loads start only while the window is open
	property p_window;
		@(posedge clk) disable iff (srst) cyc_start && cur_op == nfcs_pkg::OP_ADDSECT |->
			win_tmr < 16'(WIN_CYC);
	endproperty
	a_window: assert property (p_window) else $error("sector load issued after window closed");

	// Aborted algorithm is reissued right after reset recovery
	property p_redo;
		@(posedge clk) disable iff (srst) state == S_HREC && cnt == 8'h00 && redo |=>
			state == S_ISSUE && idx == 3'd0 ##[1:3] !flash_ce_n;
	endproperty
	a_redo: assert property (p_redo) else $error("aborted operation not reissued");

	// No command reaches the flash while it runs a program
	property p_no_cmd_busy;
		@(posedge clk) disable iff (srst) state == S_BUSY && alg_op == nfcs_pkg::OP_PROG && !sect_alg && cmd_wr
			&& cmd_code != nfcs_pkg::OP_HWRST |=> state != S_ISSUE;
	endproperty
	a_no_cmd_busy: assert property (p_no_cmd_busy) else $error("command written during program");
endmodule // nfcs_ctrl

// ===== tb/nfcs_flash_model.sv
`timescale 1ns/10ps
module nfcs_flash_model
#(
	parameter int BUSY_CYC = 30, // Algorithm length in cycles
	parameter logic [15:0] MFR_CODE = 16'h00A5, // Arbitrary maker code
	parameter logic [15:0] DEV_CODE = 16'h5A3C // Arbitrary part code
)
(
	input wire logic clk, // Model clock
	input wire logic [21:0] addr, // Address pins
	input wire logic [15:0] dq_wr, // Data from controller
	input wire logic ce_n, // Chip select
	input wire logic we_n, // Write strobe
	input wire logic oe_n, // Output enable
	input wire logic reset_n, // Hardware reset
	output logic [15:0] dq_rd, // Data to controller
	output logic ready_busy_out // 1 ready, 0 busy
);
	logic [15:0] mem [16]; // Tiny array
	logic [15:0] last; // Last word driven
	logic we_q; // Strobe one cycle ago
	logic ce_q; // Chip select one cycle ago
	int step; // Sequence position
	int busy; // Cycles left of algorithm
	logic idm; // Identifier mode
	wire [7:0] d = dq_wr[7:0]; // Command byte
	wire [7:0] lo = addr[7:0]; // Low address
	// Identifier codes or array word
	wire [15:0] rd_val = !idm ? mem[addr[3:0]] : lo == 8'h00 ? MFR_CODE : lo == 8'h01 ? DEV_CODE : 16'h0000;
	// Released bus shows inverse of last value
	assign dq_rd = (ce_n | oe_n) ? ~last : rd_val;
	// Busy while algorithm runs
	assign ready_busy_out = (busy == 0);
	initial
	begin
		foreach (mem[i]) mem[i] = 16'hFFFF;
		last = 16'h0000;
		we_q = 1'b1;
		ce_q = 1'b1;
		step = 0;
		busy = 0;
		idm = 1'b0;
	end
	// Command decoder, latching data at strobe rise
	always @(posedge clk)
	begin
		we_q <= we_n;
		ce_q <= ce_n;
		if (!ce_n && !oe_n) last <= rd_val;
		if (busy > 0) busy <= busy - 1;
		if (!reset_n)
		begin
			// Abort at once
			busy <= 0;
			step <= 0;
			idm <= 1'b0;
		end
		// Strobe rise with select held low the cycle before; writes ignored while busy
		else if (!we_q && we_n && !ce_q && busy == 0)
		begin
			if (d == nfcs_pkg::CD_RESET)
			begin
				step <= 0;
				idm <= 1'b0;
			end
			else
			case (step)
				0: step <= (addr == nfcs_pkg::UNLOCK_A1 && d == nfcs_pkg::CD_UNLOCK1) ? 1 : 0;
				1: step <= (addr == nfcs_pkg::UNLOCK_A2 && d == nfcs_pkg::CD_UNLOCK2) ? 2 : 0;
				2:
				begin
					idm <= idm | (d == nfcs_pkg::CD_ID);
					step <= (d == nfcs_pkg::CD_PROG) ? 3 : (d == nfcs_pkg::CD_ERASE) ? 4 : 0;
				end
				3:
				begin
					// Program only clears bits
					mem[addr[3:0]] <= mem[addr[3:0]] & dq_wr;
					busy <= BUSY_CYC;
					step <= 0;
				end
				4: step <= (d == nfcs_pkg::CD_UNLOCK1) ? 5 : 0;
				5: step <= (d == nfcs_pkg::CD_UNLOCK2) ? 6 : 0;
				default:
				begin
					// Pre-program and erase end as all ones
					if (d == nfcs_pkg::CD_CHIP || d == nfcs_pkg::CD_SECT)
					begin
						foreach (mem[i]) mem[i] <= 16'hFFFF;
						busy <= BUSY_CYC;
					end
					step <= 0;
				end
			endcase
		end
	end
endmodule // nfcs_flash_model

// ===== tb/test_nfcs_ctrl.sv
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin num_errors++; \
	$display("wrong value %s exp %h got %h", nm, ex, gt); end end
module test_nfcs_ctrl;
	logic clk = 1'b0; // 200 MHz clock
	logic srst = 1'b1; // Sync reset
	logic [4:0] reg_addr = 5'h00; // Register address
	logic [31:0] reg_wdata = 32'h00000000; // Register write data
	logic reg_wr = 1'b0; // Write strobe
	logic reg_rd = 1'b0; // Read strobe
	logic [31:0] reg_rdata; // Read data
	logic [21:0] flash_addr; // Flash address
	logic [15:0] flash_dq_out; // Data to flash
	logic [15:0] flash_dq_in; // Data from flash
	logic flash_dq_oe_n, flash_ce_n, flash_we_n, flash_oe_n, flash_reset_n; // Flash strobes
	logic ready_busy_out; // Flash ready pin
	int num_errors = 0; // Mismatches
	int n_compared = 0; // Comparisons
	logic [31:0] rv; // Read value
	typedef struct { logic [21:0] a; logic [15:0] d; logic [15:0] e; } nfcs_row_s;
	// Program rows: address, data, expected read back
	nfcs_row_s rows [3] = '{'{22'h000001, 16'h1234, 16'h1234}, '{22'h000001, 16'h00FF, 16'h0034},
		'{22'h000003, 16'hABCD, 16'hABCD}};
	always #2.5 clk = ~clk;
	nfcs_ctrl #(.WIN_CYC(200)) dut_u (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_addr(flash_addr),
		.flash_dq_out(flash_dq_out), .flash_dq_in(flash_dq_in), .flash_dq_oe_n(flash_dq_oe_n),
		.flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
		.flash_reset_n(flash_reset_n), .ready_busy_out(ready_busy_out));
	nfcs_flash_model flash_u (.clk(clk), .addr(flash_addr), .dq_wr(flash_dq_out), .ce_n(flash_ce_n),
		.we_n(flash_we_n), .oe_n(flash_oe_n), .reset_n(flash_reset_n), .dq_rd(flash_dq_in),
		.ready_busy_out(ready_busy_out));
	// One-cycle register write
	task automatic reg_write(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// One-cycle register read, data taken the cycle after
	task automatic reg_read(input logic [4:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// Command, then poll until idle
	task automatic do_cmd(input logic [31:0] op);
		int k;
		logic [31:0] s;
		reg_write(nfcs_pkg::REG_CMD, op);
		s = 32'h00000001;
		k = 0;
		repeat (3) @(posedge clk);
		while (s[nfcs_pkg::ST_ACTIVE] !== 1'b0 && k < 500)
		begin
			reg_read(nfcs_pkg::REG_STATUS, s);
			k++;
		end
	endtask
	// Flash read through the controller
	task automatic flash_read(input logic [21:0] a, output logic [31:0] d);
		reg_write(nfcs_pkg::REG_ADDR, {10'h000, a});
		do_cmd(32'h8);
		reg_read(nfcs_pkg::REG_RDATA, d);
	endtask
	// Counts and verdict
	task automatic finish_test();
		$display("checks %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		#1 `CHK("rdata_rst", 32'h0, reg_rdata)
		`CHK("pins_rst", 5'h1F, {flash_ce_n, flash_we_n, flash_oe_n, flash_reset_n, flash_dq_oe_n})
		foreach (rows[i])
		begin
			reg_write(nfcs_pkg::REG_ADDR, {10'h000, rows[i].a});
			reg_write(nfcs_pkg::REG_WDATA, {16'h0000, rows[i].d});
			do_cmd(32'h3);
			flash_read(rows[i].a, rv);
			`CHK("prog_rd", rows[i].e, rv[15:0])
		end
		// Identifier mode, codes and protect state
		do_cmd(32'h2);
		reg_read(nfcs_pkg::REG_STATUS, rv);
		`CHK("id_on", 1'b1, rv[nfcs_pkg::ST_IDMODE])
		flash_read(22'h000000, rv);
		`CHK("mfr", flash_u.MFR_CODE, rv[15:0])
		flash_read(22'h000001, rv);
		`CHK("dev", flash_u.DEV_CODE, rv[15:0])
		flash_read(22'h010002, rv);
		`CHK("prot", 16'h0000, rv[15:0])
		// Program refused while in identifier mode
		reg_write(nfcs_pkg::REG_CMD, 32'h3);
		repeat (2) @(posedge clk);
		reg_read(nfcs_pkg::REG_STATUS, rv);
		`CHK("id_err", 2'b11, {rv[nfcs_pkg::ST_ERR], rv[nfcs_pkg::ST_IDMODE]})
		reg_write(nfcs_pkg::REG_STATUS, 32'h40);
		do_cmd(32'h1);
		reg_read(nfcs_pkg::REG_STATUS, rv);
		`CHK("id_off", 2'b00, {rv[nfcs_pkg::ST_ERR], rv[nfcs_pkg::ST_IDMODE]})
		flash_read(22'h000003, rv);
		`CHK("array", 16'hABCD, rv[15:0])
		// Chip erase returns all ones
		do_cmd(32'h4);
		flash_read(22'h000001, rv);
		`CHK("erased", 16'hFFFF, rv[15:0])
		// Sector erase, suspend inside the load window, then resume
		reg_write(nfcs_pkg::REG_ADDR, 32'h0);
		reg_write(nfcs_pkg::REG_CMD, 32'h5);
		repeat (150) @(posedge clk);
		reg_read(nfcs_pkg::REG_STATUS, rv);
		`CHK("win", 1'b1, rv[nfcs_pkg::ST_WINDOW])
		do_cmd(32'h6);
		reg_read(nfcs_pkg::REG_STATUS, rv);
		`CHK("susp", 1'b1, rv[nfcs_pkg::ST_SUSP])
		do_cmd(32'h7);
		reg_read(nfcs_pkg::REG_STATUS, rv);
		`CHK("resume", 1'b0, rv[nfcs_pkg::ST_SUSP])
		// Hardware reset while programming, then reissue
		reg_write(nfcs_pkg::REG_ADDR, 32'h5);
		reg_write(nfcs_pkg::REG_WDATA, 32'h0F0F);
		reg_write(nfcs_pkg::REG_CMD, 32'h3);
		repeat (80) @(posedge clk);
		do_cmd(32'h9);
		flash_read(22'h000005, rv);
		`CHK("reissue", 16'h0F0F, rv[15:0])
		reg_read(5'h14, rv);
		`CHK("unmapped", 32'h0, rv)
		finish_test();
	end
	// Watchdog
	initial
	begin
		#400000;
		num_errors++;
		finish_test();
	end
endmodule // test_nfcs_ctrl
